// file: design/hscc_pkg.sv
package hscc_pkg;

  localparam int HSCC_DW = 32;
  localparam int HSCC_AW = 8;
  localparam int HSCC_NCNT = 2;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] ADDR_NEWCUR0 = 8'h04;
  localparam logic [7:0] ADDR_NEWPRE0 = 8'h08;
  localparam logic [7:0] ADDR_CNT_STRIDE = 8'h0c;
  localparam logic [7:0] ADDR_MODE_DEF = 8'h18;
  localparam logic [7:0] ADDR_APPLY = 8'h1c;
  localparam logic [7:0] ADDR_STATUS0 = 8'h20;
  localparam logic [7:0] ADDR_STATUS1 = 8'h24;
  localparam logic [7:0] ADDR_CUR0 = 8'h28;
  localparam logic [7:0] ADDR_CUR1 = 8'h2c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h30;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h34;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h38;
  localparam logic [7:0] ADDR_GIE = 8'h3c;
  localparam logic [7:0] ADDR_MODE_RB = 8'h40;

  // Control byte fields
  localparam int CB_EN = 7;
  localparam int CB_LDCUR = 6;
  localparam int CB_LDPRE = 5;
  localparam int CB_UPDIR = 4;
  localparam int CB_DIRUP = 3;
  localparam int CB_RATE1 = 2;
  localparam int CB_SPOL = 1;
  localparam int CB_RPOL = 0;

  // Status byte fields
  localparam int ST_DIR = 5;
  localparam int ST_EQ = 6;
  localparam int ST_GT = 7;

  // Mode define and apply fields
  localparam int MD_SEL = 8;
  localparam int AP_SEL = 0;

  // Counting modes
  localparam logic [3:0] MODE_INT_LAST = 4'h2;
  localparam logic [3:0] MODE_EXT_LAST = 4'h5;
  localparam logic [3:0] MODE_UPDN_LAST = 4'h8;
  localparam logic [3:0] MODE_QUAD_NONE = 4'h9;
  localparam logic [3:0] MODE_QUAD_RST = 4'ha;
  localparam logic [3:0] MODE_QUAD_BOTH = 4'hb;
  localparam logic [3:0] MODE_PGEN = 4'hc;

  // Interrupt status bits
  localparam int HSCC_NEV = 5;
  localparam int EV_C0_EQ = 0;
  localparam int EV_C1_EQ = 1;
  localparam int EV_C1_DIR = 2;
  localparam int EV_C1_RST = 3;
  localparam int EV_DEF_ERR = 4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    HSCC_OFF = 2'b00,
    HSCC_RUN = 2'b01,
    HSCC_LOAD = 2'b10
  } hscc_state_t;

endpackage

// file: design/hscc_axil.sv
`timescale 1ns/1ps
module hscc_axil
  import hscc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [HSCC_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [HSCC_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [HSCC_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [HSCC_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en,
  output logic [HSCC_AW-1:0] wr_addr,
  output logic [HSCC_DW-1:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  input wire logic [HSCC_DW-1:0] rd_data,
  input wire logic rd_ok
);

  logic aw_got;
  logic w_got;

  assign wr_en = aw_got && w_got && !s_axi_bvalid;

  // Write address and data, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        s_axi_awready <= 1'b0;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        s_axi_wready <= 1'b0;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (wr_en) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// file: design/hscc_top.sv
`timescale 1ns/1ps
module hscc_top
  import hscc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [HSCC_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [HSCC_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [HSCC_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [HSCC_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [HSCC_NCNT-1:0] cnt_phase_a,
  input wire logic [HSCC_NCNT-1:0] cnt_phase_b,
  input wire logic [HSCC_NCNT-1:0] cnt_ext_start,
  input wire logic [HSCC_NCNT-1:0] cnt_ext_reset,
  input wire logic pulse_generator_zero,
  output logic irq
);

  logic wr_en;
  logic [HSCC_AW-1:0] wr_addr;
  logic [HSCC_DW-1:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic [HSCC_DW-1:0] rd_data;
  logic rd_ok;

  logic [7:0] ctrl_byte [HSCC_NCNT];
  logic [31:0] new_cur [HSCC_NCNT];
  logic [31:0] new_pre [HSCC_NCNT];
  logic [31:0] cur_val [HSCC_NCNT];
  logic [31:0] pre_val [HSCC_NCNT];
  logic [3:0] mode [HSCC_NCNT];
  logic [HSCC_NCNT-1:0] defined;
  logic [HSCC_NCNT-1:0] dir_up;
  logic [HSCC_NCNT-1:0] eq_now;
  logic [HSCC_NCNT-1:0] gt_now;
  logic [HSCC_NCNT-1:0] ev_eq;
  logic [HSCC_NCNT-1:0] ev_dir;
  logic [HSCC_NCNT-1:0] ev_rst;
  logic [HSCC_NCNT-1:0] def_err;

  logic [HSCC_NEV-1:0] irq_stat;
  logic [HSCC_NEV-1:0] irq_en;
  logic [HSCC_NEV-1:0] irq_set;
  logic gie;

  logic apply_hit;
  logic def_hit;

  hscc_axil i_hscc_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic has_reset(input logic [3:0] m);
    case (m)
      4'h1, 4'h2, 4'h4, 4'h5, 4'h7, 4'h8, MODE_QUAD_RST, MODE_QUAD_BOTH:
        has_reset = 1'b1;
      default: has_reset = 1'b0;
    endcase
  endfunction

  function automatic logic has_start(input logic [3:0] m);
    case (m)
      4'h2, 4'h5, 4'h8, MODE_QUAD_BOTH: has_start = 1'b1;
      default: has_start = 1'b0;
    endcase
  endfunction

  function automatic logic sw_dir_mode(input logic [3:0] m);
    sw_dir_mode = (m <= MODE_INT_LAST) || (m == MODE_PGEN);
  endfunction

  assign apply_hit = wr_en && (wr_addr == ADDR_APPLY) && wr_strb[0];
  assign def_hit = wr_en && (wr_addr == ADDR_MODE_DEF) && wr_strb[1];

  genvar g;
  generate
    for (g = 0; g < HSCC_NCNT; g++) begin : g_cnt
      localparam logic [7:0] A_CTRL = 8'(ADDR_CTRL0 + g * ADDR_CNT_STRIDE);
      localparam logic [7:0] A_CUR = 8'(ADDR_NEWCUR0 + g * ADDR_CNT_STRIDE);
      localparam logic [7:0] A_PRE = 8'(ADDR_NEWPRE0 + g * ADDR_CNT_STRIDE);
      hscc_state_t state;
      hscc_state_t next_state;
      logic apply;
      logic define;
      logic [3:0] def_mode;
      logic bad_mode;
      logic rate1;
      logic spol;
      logic rpol;
      logic a_q;
      logic b_q;
      logic gen_q;
      logic rst_q;
      logic eq_q;
      logic rise_a;
      logic rise_b;
      logic rise_gen;
      logic rst_lvl;
      logic start_ok;
      logic step_up;
      logic step_dn;
      logic [3:0] quad;

      // Values act only on apply
      // apply gates all but mode, which define sets at once
      assign apply = apply_hit && (wr_data[AP_SEL] == 1'(g)) && defined[g];
      assign define = def_hit && (wr_data[MD_SEL] == 1'(g));
      assign def_mode = wr_data[3:0];
      assign bad_mode = (def_mode > MODE_PGEN) ||
                        ((def_mode == MODE_PGEN) && (g != 0));

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ctrl_byte[g] <= '0;
          new_cur[g] <= '0;
          new_pre[g] <= '0;
        end else if (wr_en) begin
          if (wr_addr == A_CTRL && wr_strb[0]) begin
            ctrl_byte[g] <= wr_data[7:0];
          end
          if (wr_addr == A_CUR) begin
            new_cur[g] <= merge(new_cur[g], wr_data, wr_strb);
          end
          if (wr_addr == A_PRE) begin
            new_pre[g] <= merge(new_pre[g], wr_data, wr_strb);
          end
        end
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          mode[g] <= '0;
          defined[g] <= 1'b0;
          def_err[g] <= 1'b0;
        end else begin
          def_err[g] <= define && (defined[g] || bad_mode);
          if (define && !defined[g] && !bad_mode) begin
            mode[g] <= def_mode;
            defined[g] <= 1'b1;
          end
        end
      end

      always_comb begin
        next_state = state;
        case (state)
          HSCC_OFF, HSCC_RUN: begin
            if (apply) begin
              if (!ctrl_byte[g][CB_EN]) begin
                next_state = HSCC_OFF;
              end else if (ctrl_byte[g][CB_LDCUR]) begin
                next_state = HSCC_LOAD;
              end else begin
                next_state = HSCC_RUN;
              end
            end
          end
          HSCC_LOAD: next_state = HSCC_RUN;
          default: next_state = HSCC_OFF;
        endcase
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          state <= HSCC_OFF;
        end else begin
          state <= next_state;
        end
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          rate1 <= 1'b0;
          spol <= 1'b0;
          rpol <= 1'b0;
        end else if (apply && ctrl_byte[g][CB_EN] &&
                     ctrl_byte[g][CB_UPDIR]) begin
          rate1 <= ctrl_byte[g][CB_RATE1];
          spol <= ctrl_byte[g][CB_SPOL];
          rpol <= ctrl_byte[g][CB_RPOL];
        end
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          a_q <= 1'b0;
          b_q <= 1'b0;
          gen_q <= 1'b0;
          rst_q <= 1'b0;
          eq_q <= 1'b0;
        end else begin
          a_q <= cnt_phase_a[g];
          b_q <= cnt_phase_b[g];
          gen_q <= pulse_generator_zero;
          rst_q <= rst_lvl;
          eq_q <= eq_now[g];
        end
      end

      assign rise_a = cnt_phase_a[g] && !a_q;
      assign rise_b = cnt_phase_b[g] && !b_q;
      assign rise_gen = pulse_generator_zero && !gen_q;
      assign rst_lvl = has_reset(mode[g]) && (cnt_ext_reset[g] ^ rpol);
      assign start_ok = !has_start(mode[g]) || (cnt_ext_start[g] ^ spol);
      assign quad = {a_q, b_q, cnt_phase_a[g], cnt_phase_b[g]};

      // Count step per mode
      always_comb begin
        step_up = 1'b0;
        step_dn = 1'b0;
        if (mode[g] <= MODE_INT_LAST) begin
          step_up = rise_a && dir_up[g];
          step_dn = rise_a && !dir_up[g];
        end else if (mode[g] <= MODE_EXT_LAST) begin
          step_up = rise_a && cnt_phase_b[g];
          step_dn = rise_a && !cnt_phase_b[g];
        end else if (mode[g] <= MODE_UPDN_LAST) begin
          step_up = rise_a && !rise_b;
          step_dn = rise_b && !rise_a;
        end else if (mode[g] <= MODE_QUAD_BOTH) begin
          if (rate1) begin
            step_up = rise_a && !cnt_phase_b[g];
            step_dn = rise_a && cnt_phase_b[g];
          end else begin
            case (quad)
              4'b0010, 4'b1011, 4'b1101, 4'b0100: step_up = 1'b1;
              4'b0001, 4'b0111, 4'b1110, 4'b1000: step_dn = 1'b1;
              default: step_up = 1'b0;
            endcase
          end
        end else if (mode[g] == MODE_PGEN) begin
          step_up = rise_gen && dir_up[g];
          step_dn = rise_gen && !dir_up[g];
        end
      end

      // Current and preset values
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cur_val[g] <= '0;
          pre_val[g] <= '0;
        end else if (apply && ctrl_byte[g][CB_EN]) begin
          if (ctrl_byte[g][CB_LDCUR]) begin
            cur_val[g] <= new_cur[g];
          end
          if (ctrl_byte[g][CB_LDPRE]) begin
            pre_val[g] <= new_pre[g];
          end
        end else if (state == HSCC_RUN) begin
          if (rst_lvl && !rst_q) begin
            cur_val[g] <= '0;
          end else if (start_ok && step_up) begin
            cur_val[g] <= cur_val[g] + 32'h1;
          end else if (start_ok && step_dn) begin
            cur_val[g] <= cur_val[g] - 32'h1;
          end
        end
      end

      // Direction and events
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          dir_up[g] <= 1'b1;
          ev_dir[g] <= 1'b0;
          ev_rst[g] <= 1'b0;
          ev_eq[g] <= 1'b0;
        end else begin
          ev_dir[g] <= 1'b0;
          ev_rst[g] <= (state == HSCC_RUN) && !apply && rst_lvl && !rst_q;
          ev_eq[g] <= (state == HSCC_RUN) && !apply && eq_now[g] && !eq_q;
          if (apply && ctrl_byte[g][CB_EN] && ctrl_byte[g][CB_UPDIR] &&
              sw_dir_mode(mode[g])) begin
            dir_up[g] <= ctrl_byte[g][CB_DIRUP];
          end else if (state == HSCC_RUN && !apply && start_ok &&
                       !sw_dir_mode(mode[g]) && (step_up || step_dn)) begin
            dir_up[g] <= step_up;
            ev_dir[g] <= (step_up != dir_up[g]);
          end
        end
      end

      assign eq_now[g] = (cur_val[g] == pre_val[g]);
      assign gt_now[g] = ($signed(cur_val[g]) > $signed(pre_val[g]));
    end
  endgenerate

  always_comb begin
    irq_set = '0;
    irq_set[EV_C0_EQ] = ev_eq[0];
    irq_set[EV_C1_EQ] = ev_eq[1];
    irq_set[EV_C1_DIR] = ev_dir[1];
    irq_set[EV_C1_RST] = ev_rst[1];
    irq_set[EV_DEF_ERR] = |def_err;
  end

  // Sticky status, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= '0;
    end else if (wr_en && wr_addr == ADDR_IRQ_CLR) begin
      irq_stat <= (irq_stat & ~wr_data[HSCC_NEV-1:0]) | irq_set;
    end else begin
      irq_stat <= irq_stat | irq_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en <= '0;
      gie <= 1'b0;
    end else if (wr_en && wr_strb[0]) begin
      if (wr_addr == ADDR_IRQ_EN) begin
        irq_en <= wr_data[HSCC_NEV-1:0];
      end
      if (wr_addr == ADDR_GIE) begin
        gie <= wr_data[0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= gie && |(irq_stat & irq_en);
    end
  end

  always_comb begin
    case (wr_addr)
      ADDR_CTRL0, ADDR_NEWCUR0, ADDR_NEWPRE0,
      8'(ADDR_CTRL0 + ADDR_CNT_STRIDE), 8'(ADDR_NEWCUR0 + ADDR_CNT_STRIDE),
      8'(ADDR_NEWPRE0 + ADDR_CNT_STRIDE), ADDR_MODE_DEF, ADDR_APPLY,
      ADDR_IRQ_CLR, ADDR_IRQ_EN, ADDR_GIE: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // Register read mux
  always_comb begin
    rd_data = '0;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      ADDR_CTRL0: rd_data[7:0] = ctrl_byte[0];
      ADDR_NEWCUR0: rd_data = new_cur[0];
      ADDR_NEWPRE0: rd_data = new_pre[0];
      8'(ADDR_CTRL0 + ADDR_CNT_STRIDE): rd_data[7:0] = ctrl_byte[1];
      8'(ADDR_NEWCUR0 + ADDR_CNT_STRIDE): rd_data = new_cur[1];
      8'(ADDR_NEWPRE0 + ADDR_CNT_STRIDE): rd_data = new_pre[1];
      ADDR_MODE_DEF, ADDR_APPLY, ADDR_IRQ_CLR: rd_data = '0;
      ADDR_STATUS0: begin
        rd_data[ST_DIR] = dir_up[0];
        rd_data[ST_EQ] = eq_now[0];
        rd_data[ST_GT] = gt_now[0];
      end
      ADDR_STATUS1: begin
        rd_data[ST_DIR] = dir_up[1];
        rd_data[ST_EQ] = eq_now[1];
        rd_data[ST_GT] = gt_now[1];
      end
      ADDR_CUR0: rd_data = cur_val[0];
      ADDR_CUR1: rd_data = cur_val[1];
      ADDR_IRQ_STAT: rd_data[HSCC_NEV-1:0] = irq_stat;
      ADDR_IRQ_EN: rd_data[HSCC_NEV-1:0] = irq_en;
      ADDR_GIE: rd_data[0] = gie;
      ADDR_MODE_RB: rd_data = {19'h0, defined[1], mode[1], 3'h0,
                               defined[0], mode[0]};
      default: rd_ok = 1'b0;
    endcase
  end

endmodule

// file: verif/hscc_enc.sv
`timescale 1ns/1ps
module hscc_enc (
  input wire logic aclk,
  input wire logic step,
  input wire logic up,
  output logic phase_a,
  output logic phase_b,
  output logic pulse
);
  logic [1:0] pos = 2'h0;

  // Quarter steps in gray order, phase A leads B when up
  always @(posedge aclk) begin
    if (step) begin
      pos <= up ? pos + 2'h1 : pos - 2'h1;
    end
    pulse <= step;
  end

  assign phase_a = pos[1] ^ pos[0];
  assign phase_b = pos[1];
endmodule

// file: verif/hscc_sva.sv
`timescale 1ns/1ps
module hscc_sva
  import hscc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [HSCC_DW-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic [2:0] since_b;

  // Cycles since the last write answer
  always_ff @(posedge aclk) begin
    if (!aresetn || s_axi_bvalid) begin
      since_b <= 3'h0;
    end else if (since_b != 3'h7) begin
      since_b <= since_b + 3'h1;
    end
  end

  wr_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write not answered");
  b_blocks_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during answer");
  b_done_a: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready
    && s_axi_wready) else $error("write answer not closed");
  rd_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered");
  rd_done_a: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read answer not closed");
  r_blocks_a: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken twice");
  slverr_zero_a: assert property (
    s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("refused read carries data");
  irq_clear_a: assert property (
    $fell(irq) |-> since_b < 3'h5) else $error("irq fell unprompted");

  wr_c: cover property (s_axi_bvalid && s_axi_bready);
  err_c: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  irq_c: cover property ($rose(irq));
endmodule

bind hscc_top hscc_sva i_hscc_sva (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);

// file: verif/hscc_bench.sv
`timescale 1ns/1ps
module hscc_bench
  import hscc_pkg::*;
;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic [1:0] ext_rst = 2'h0;
  logic [1:0] ext_start = 2'h2;
  logic step = 1'h0;
  logic up = 1'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq, enc_a, enc_b, enc_p;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rdat;
  int miscompares = 0;
  int cmp_count = 0;

  always #10 aclk = ~aclk;

  hscc_enc i_hscc_enc (.aclk(aclk), .step(step), .up(up),
    .phase_a(enc_a), .phase_b(enc_b), .pulse(enc_p));

  hscc_top i_hscc_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .cnt_phase_a({enc_a, 1'h0}), .cnt_phase_b({enc_b, 1'h0}),
    .cnt_ext_start(ext_start), .cnt_ext_reset(ext_rst),
    .pulse_generator_zero(enc_p), .irq);

  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
    chk(rdat, e);
  endtask

  task automatic ap(input logic c, input logic [31:0] v);
    wr(c ? ADDR_CNT_STRIDE : ADDR_CTRL0, v);
    wr(ADDR_APPLY, {31'h0, c});
  endtask

  task automatic mv(input int n, input logic u);
    up <= u;
    repeat (n) begin
      @(posedge aclk);
      step <= 1'h1;
      @(posedge aclk);
      step <= 1'h0;
    end
    repeat (3) @(posedge aclk);
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    wr(ADDR_MODE_DEF, 32'h10b);
    wr(ADDR_MODE_DEF, 32'h00c);
    wr(ADDR_IRQ_EN, 32'h1f);
    wr(ADDR_GIE, 32'h1);
    chk(resp, RESP_OKAY);
    rc(ADDR_MODE_RB, 32'h1b1c);
    chk(resp, RESP_OKAY);
    wr(8'hfc, 32'h1);
    chk(resp, RESP_SLVERR);
    rc(8'hfc, 32'h0);
    chk(resp, RESP_SLVERR);
    wr(ADDR_NEWCUR0 + ADDR_CNT_STRIDE, 32'h0);
    wr(ADDR_NEWPRE0 + ADDR_CNT_STRIDE, 32'h2);
    wr(ADDR_CNT_STRIDE, 32'hfc);
    wr(ADDR_APPLY, 32'h1);
    mv(8, 1'h1);
    rc(ADDR_CUR1, 32'h2);
    rc(ADDR_STATUS1, 32'h60);
    rc(ADDR_IRQ_STAT, 32'h2);
    chk(irq, 1'h1);
    ap(1'h1, 32'hf8);
    mv(4, 1'h1);
    rc(ADDR_CUR1, 32'h4);
    rc(ADDR_STATUS1, 32'ha0);
    ap(1'h1, 32'h90);
    rc(ADDR_STATUS1, 32'ha0);
    wr(ADDR_IRQ_CLR, 32'h1f);
    mv(4, 1'h0);
    rc(ADDR_CUR1, 32'h0);
    rc(ADDR_IRQ_STAT, 32'h6);
    wr(ADDR_NEWCUR0 + ADDR_CNT_STRIDE, 32'h5);
    wr(ADDR_NEWPRE0 + ADDR_CNT_STRIDE, 32'h7);
    rc(ADDR_CUR1, 32'h0);
    ap(1'h1, 32'hc0);
    rc(ADDR_CUR1, 32'h5);
    rc(ADDR_STATUS1, 32'h80);
    wr(ADDR_NEWCUR0 + ADDR_CNT_STRIDE, 32'h9);
    ap(1'h1, 32'ha0);
    rc(ADDR_CUR1, 32'h5);
    rc(ADDR_STATUS1, 32'h0);
    wr(ADDR_IRQ_CLR, 32'h1f);
    ext_rst <= 2'h2;
    repeat (2) @(posedge aclk);
    ext_rst <= 2'h0;
    rc(ADDR_CUR1, 32'h0);
    rc(ADDR_IRQ_STAT, 32'h8);
    ext_start <= 2'h0;
    mv(4, 1'h1);
    rc(ADDR_CUR1, 32'h0);
    ext_start <= 2'h2;
    ap(1'h1, 32'h0);
    mv(4, 1'h1);
    rc(ADDR_CUR1, 32'h0);
    wr(ADDR_NEWPRE0, 32'h3);
    ap(1'h0, 32'hf8);
    wr(ADDR_IRQ_CLR, 32'h1f);
    mv(3, 1'h0);
    rc(ADDR_CUR0, 32'h3);
    rc(ADDR_IRQ_STAT, 32'h1);
    ap(1'h0, 32'h90);
    rc(ADDR_STATUS0, 32'h40);
    mv(2, 1'h1);
    rc(ADDR_CUR0, 32'h1);
    ap(1'h0, 32'h98);
    rc(ADDR_STATUS0, 32'h20);
    wr(ADDR_IRQ_CLR, 32'h1f);
    wr(ADDR_IRQ_EN, 32'hf);
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_MODE_DEF, i == 0 ? 32'h109 : 32'h00b);
      rc(ADDR_IRQ_STAT, 32'h10);
    end
    chk(irq, 1'h0);
    rc(ADDR_MODE_RB, 32'h1b1c);
    wr(ADDR_IRQ_EN, 32'h1f);
    rc(ADDR_IRQ_STAT, 32'h10);
    chk(irq, 1'h1);
    wr(ADDR_IRQ_CLR, 32'h10);
    rc(ADDR_IRQ_STAT, 32'h0);
    chk(irq, 1'h0);
    finish_test;
  end

  initial begin
    repeat (5000) @(posedge aclk);
    miscompares++;
    finish_test;
  end
endmodule
